// ---- src/bff_framer.sv ----
`timescale 1ns/10ps
module bff_framer #(
  parameter logic [7:0]  LIVENESS_CMD    = 8'h82,
  parameter logic [7:0]  STATUS_WORKING  = 8'h01,
  parameter logic [7:0]  STATUS_PRESENCE = 8'h02,
  parameter logic [7:0]  CANCEL_CMD      = 8'hbe,
  parameter int unsigned LIVENESS_COUNT  = bff_pkg::LIVENESS_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // command_write_attribute: one write delivers one fragment
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  input  wire logic        rx_last,
  // application side: reassembled request payload
  output logic [7:0]       req_data,
  output logic             req_valid,
  output logic             req_start,
  output logic [7:0]       req_cmd,
  output logic [15:0]      req_len,
  output logic             cancel_pulse,
  input  wire logic        busy_working,
  input  wire logic        busy_presence,
  // reply payload from application
  input  wire logic        reply_start,
  input  wire logic [7:0]  reply_cmd,
  input  wire logic [15:0] reply_len,
  input  wire logic [7:0]  reply_data,
  input  wire logic        reply_valid,
  output logic             reply_ready,
  // status_notify_attribute: bytes with end of notification marker
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  output logic             tx_last,
  input  wire logic        tx_ready,
  input  wire logic [9:0]  att_mtu,
  // registration kept per bond by persistent store outside
  input  wire logic        bond_notify_enabled,
  output logic             notify_enabled,
  // scan response service data
  input  wire logic        pairing_mode,
  input  wire logic        passkey_required,
  output logic [7:0]       svc_flags,
  output logic [1:0]       svc_flag_len
);
  typedef enum logic [3:0] {
    TX_IDLE     = 4'b0001,
    TX_HDR      = 4'b0010,
    TX_SEQUENCE = 4'b0100,
    TX_DATA     = 4'b1000
  } bff_tx_t;

  typedef struct packed {
    bff_tx_t     tx_st;
    logic [1:0]  hdr_idx;
    bff_pkg::bff_hdr_t hdr;
    logic        is_live;
    logic [15:0] remain;
    logic [9:0]  frag_cnt;
    logic [6:0]  tx_sequence;
    logic [31:0] live_cnt;
    logic        pending;
    logic        live_due;
    logic        rx_in_frag;
    logic [1:0]  rx_idx;
    logic        rx_hdr_done;
    logic [15:0] rx_remain;
    logic [7:0]  req_data;
    logic        req_valid;
    logic        req_start;
    logic [7:0]  req_cmd;
    logic [15:0] req_len;
    logic        cancel_pulse;
    logic [7:0]  svc_flags;
    logic [1:0]  svc_flag_len;
    logic        notify_en;
  } bff_state_t;

  bff_state_t st_reg;
  bff_state_t st_next;
  logic [7:0] rx_s1_reg, rx_s2_reg;
  logic       rv_s1_reg, rv_s2_reg, rl_s1_reg, rl_s2_reg;
  logic [9:0] frag_limit;
  logic [7:0] fifo_out_data;
  logic       fifo_out_valid;
  logic       fifo_pop;
  logic [7:0] tx_byte;
  logic       tx_go;
  logic       live_tick;

  // fifo buffers reply payload; its ready throttles the application
  bff_fifo #(.WIDTH(8), .DEPTH(8)) u_fifo (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .in_data   (reply_data),
    .in_valid  (reply_valid),
    .in_ready  (reply_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop)
  );

  // radio inputs come from another domain
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rx_s1_reg <= 8'h00;
      rx_s2_reg <= 8'h00;
      rv_s1_reg <= 1'b0;
      rv_s2_reg <= 1'b0;
      rl_s1_reg <= 1'b0;
      rl_s2_reg <= 1'b0;
    end else begin
      rx_s1_reg <= rx_data;
      rx_s2_reg <= rx_s1_reg;
      rv_s1_reg <= rx_valid;
      rv_s2_reg <= rv_s1_reg;
      rl_s1_reg <= rx_last;
      rl_s2_reg <= rl_s1_reg;
    end
  end

  assign frag_limit = att_mtu - 10'(bff_pkg::MTU_OVERHEAD);
  assign tx_go      = tx_valid && tx_ready;
  assign fifo_pop   = tx_go && (st_reg.tx_st == TX_DATA) && !st_reg.is_live;
  assign live_tick  = st_reg.pending && (st_reg.live_cnt == LIVENESS_COUNT - 1);

  always_comb begin
    unique case (st_reg.hdr_idx)
      2'd0:    tx_byte = st_reg.hdr.cmd | bff_pkg::INIT_MARK;
      2'd1:    tx_byte = st_reg.hdr.len[15:8];
      default: tx_byte = st_reg.hdr.len[7:0];
    endcase
  end

  always_comb begin
    st_next              = st_reg;
    st_next.req_valid    = 1'b0;
    st_next.req_start    = 1'b0;
    st_next.cancel_pulse = 1'b0;
    st_next.notify_en    = bond_notify_enabled;
    st_next.svc_flags    = 8'h00;
    st_next.svc_flags[bff_pkg::FLAG_PAIRING_BIT] = pairing_mode;
    st_next.svc_flags[bff_pkg::FLAG_PASSKEY_BIT] = passkey_required;
    st_next.svc_flag_len = 2'd1;  // single flag octet always kept

    // receive reassembly
    if (rv_s2_reg) begin
      if (!st_reg.rx_in_frag && rx_s2_reg[7]) begin
        st_next.rx_idx = 2'd1;
        st_next.req_cmd = rx_s2_reg;
        st_next.rx_hdr_done = 1'b0;
      end else if (!st_reg.rx_in_frag) begin
        st_next.rx_idx = 2'd3;  // sequence byte skipped
      end else if (st_reg.rx_idx == 2'd1) begin
        st_next.req_len[15:8] = rx_s2_reg;
        st_next.rx_idx = 2'd2;
      end else if (st_reg.rx_idx == 2'd2) begin
        st_next.req_len[7:0] = rx_s2_reg;
        st_next.rx_remain = {st_reg.req_len[15:8], rx_s2_reg};
        st_next.rx_idx = 2'd3;
        st_next.rx_hdr_done = 1'b1;
        if (st_reg.req_cmd == CANCEL_CMD) begin
          st_next.cancel_pulse = 1'b1;  // no reply, no new liveness; a request already pending keeps its notices
        end else begin
          st_next.req_start = 1'b1;
          st_next.pending = 1'b1;
          st_next.live_cnt = '0;
        end
      end else if (st_reg.rx_remain != 16'h0000) begin
        st_next.req_data = rx_s2_reg;
        st_next.req_valid = 1'b1;
        st_next.rx_remain = st_reg.rx_remain - 16'h0001;
      end
      st_next.rx_in_frag = !rl_s2_reg;  // one fragment per write
    end

    // liveness timer
    if (st_reg.pending) begin
      if (live_tick) begin
        st_next.live_cnt = '0;
        st_next.live_due = 1'b1;
      end else begin
        st_next.live_cnt = st_reg.live_cnt + 32'd1;
      end
    end

    // transmit sequencer
    unique case (st_reg.tx_st)
      TX_IDLE: begin
        st_next.hdr_idx = 2'd0;
        st_next.tx_sequence = 7'h00;
        st_next.frag_cnt = 10'(bff_pkg::INIT_HDR_BYTES);
        if (reply_start && st_reg.pending) begin
          st_next.pending = 1'b0;  // notices stop
          st_next.live_due = 1'b0;
          st_next.is_live = 1'b0;
          st_next.hdr = '{cmd: reply_cmd, len: reply_len};
          st_next.remain = reply_len;
          st_next.tx_st = TX_HDR;
        end else if (st_reg.live_due && st_reg.notify_en) begin
          // a tick landing on the take is kept, else one notice is lost
          st_next.live_due = live_tick;
          st_next.is_live = 1'b1;
          st_next.hdr.cmd = LIVENESS_CMD;
          st_next.hdr.len = 16'h0001;
          st_next.remain = 16'h0001;
          st_next.tx_st = TX_HDR;
        end
      end
      TX_HDR: begin
        if (tx_go) begin
          if (st_reg.hdr_idx == 2'd2) begin
            st_next.tx_st = (st_reg.remain == 16'h0000) ? TX_IDLE : TX_DATA;
          end else begin
            st_next.hdr_idx = st_reg.hdr_idx + 2'd1;
          end
        end
      end
      TX_SEQUENCE: begin
        if (tx_go) begin
          st_next.tx_sequence = st_reg.tx_sequence + 7'h01;  // wraps after 0x7f
          st_next.frag_cnt = 10'(bff_pkg::CONT_HDR_BYTES);
          st_next.tx_st = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_go) begin
          st_next.remain = st_reg.remain - 16'h0001;
          st_next.frag_cnt = st_reg.frag_cnt + 10'd1;
          if (st_reg.remain == 16'h0001) begin
            st_next.tx_st = TX_IDLE;
          end else if (st_reg.frag_cnt + 10'd1 == frag_limit) begin
            st_next.tx_st = TX_SEQUENCE;
          end
        end
      end
      default: st_next.tx_st = TX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_reg <= '{tx_st: TX_IDLE, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // tx byte and flags decoded combinationally from state registers, fifo output, busy_presence input and att_mtu (via frag_limit)
  always_comb begin
    tx_valid = 1'b0;
    tx_data  = 8'h00;
    tx_last  = 1'b0;
    unique case (st_reg.tx_st)
      TX_HDR: begin
        tx_valid = 1'b1;
        tx_data  = tx_byte;
        tx_last  = (st_reg.hdr_idx == 2'd2) && (st_reg.remain == 16'h0000);
      end
      TX_SEQUENCE: begin
        tx_valid = 1'b1;
        tx_data  = {1'b0, st_reg.tx_sequence};
      end
      TX_DATA: begin
        tx_valid = st_reg.is_live || fifo_out_valid;
        // presence wait takes priority over working
        // status follows the inputs live, so it may change while stalled
        tx_data  = !st_reg.is_live ? fifo_out_data :
                   busy_presence   ? STATUS_PRESENCE : STATUS_WORKING;
        tx_last  = (st_reg.remain == 16'h0001) ||
                   (st_reg.frag_cnt + 10'd1 == frag_limit);
      end
      default: begin
        tx_valid = 1'b0;
      end
    endcase
  end

  assign req_data       = st_reg.req_data;
  assign req_valid      = st_reg.req_valid;
  assign req_start      = st_reg.req_start;
  assign req_cmd        = st_reg.req_cmd;
  assign req_len        = st_reg.req_len;
  assign cancel_pulse   = st_reg.cancel_pulse;
  assign notify_enabled = st_reg.notify_en;
  assign svc_flags      = st_reg.svc_flags;
  assign svc_flag_len   = st_reg.svc_flag_len;

  // a reply taken on the tick itself clears pending, so no notice is due then
  AST_LIVE_PERIOD: assert property (@(posedge core_clk) disable iff (!reset_n)
    live_tick |=> st_reg.live_due || !st_reg.pending)
    else $error("liveness notice not scheduled");
  AST_LIVE_PENDING: assert property (@(posedge core_clk) disable iff (!reset_n)
    st_reg.live_due |-> st_reg.pending)
    else $error("notice due without pending request");
  AST_INIT_MSB: assert property (@(posedge core_clk) disable iff (!reset_n)
    tx_valid && st_reg.tx_st == TX_HDR && st_reg.hdr_idx == 2'd0 |-> tx_data[7])
    else $error("init fragment msb clear");
  AST_SEQUENCE_MSB: assert property (@(posedge core_clk) disable iff (!reset_n)
    st_reg.tx_st == TX_SEQUENCE |-> !tx_data[7] && !tx_last)
    else $error("sequence byte malformed");
  AST_SEQUENCE_STEP: assert property (@(posedge core_clk) disable iff (!reset_n)
    st_reg.tx_st == TX_SEQUENCE && tx_go
    |=> st_reg.tx_sequence == $past(st_reg.tx_sequence) + 7'h01)
    else $error("sequence not incremented");
  AST_FRAG_CHAIN: assert property (@(posedge core_clk) disable iff (!reset_n)
    st_reg.tx_st == TX_DATA && tx_go && tx_last && st_reg.remain != 16'h0001
    |=> st_reg.tx_st == TX_SEQUENCE)
    else $error("full fragment not followed by a continuation");
  AST_FRAG_LEN: assert property (@(posedge core_clk) disable iff (!reset_n)
    st_reg.tx_st == TX_DATA |-> st_reg.frag_cnt < frag_limit)
    else $error("fragment longer than the limit");
  AST_HOLD: assert property (@(posedge core_clk) disable iff (!reset_n)
    tx_valid && !tx_ready && !(st_reg.is_live && st_reg.tx_st == TX_DATA)
    |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("notification byte changed while stalled");
  AST_STATUS: assert property (@(posedge core_clk) disable iff (!reset_n)
    st_reg.is_live && st_reg.tx_st == TX_DATA && busy_presence
    |-> tx_data == STATUS_PRESENCE)
    else $error("wrong liveness status");
  AST_STATUS_WORKING: assert property (@(posedge core_clk) disable iff (!reset_n)
    st_reg.is_live && st_reg.tx_st == TX_DATA && busy_working && !busy_presence
    |-> tx_data == STATUS_WORKING)
    else $error("working status missing");
  AST_STOP_ON_REPLY: assert property (@(posedge core_clk) disable iff (!reset_n)
    st_reg.tx_st == TX_IDLE && reply_start && st_reg.pending
    |=> !st_reg.pending && !st_reg.is_live)
    else $error("notices not stopped");
  AST_NOTIFY_OFF: assert property (@(posedge core_clk) disable iff (!reset_n)
    st_reg.tx_st == TX_IDLE && !st_reg.notify_en && !(reply_start && st_reg.pending)
    |=> st_reg.tx_st == TX_IDLE)
    else $error("notice sent while notifications disabled");
  AST_CANCEL_NO_REPLY: assert property (@(posedge core_clk) disable iff (!reset_n)
    st_reg.cancel_pulse |-> !st_reg.req_start)
    else $error("cancel produced a request");
  AST_FLAGS: assert property (@(posedge core_clk) disable iff (!reset_n)
    1'b1 |=> svc_flags == {$past(pairing_mode), $past(passkey_required), 6'h00}
    && svc_flag_len == 2'd1)
    else $error("service flags mismatch");

  COV_LIVE: cover property (@(posedge core_clk) st_reg.is_live && tx_last && tx_go);
  COV_PRESENCE: cover property (@(posedge core_clk)
    st_reg.is_live && st_reg.tx_st == TX_DATA && busy_presence && tx_go);
  COV_CONT: cover property (@(posedge core_clk) st_reg.tx_st == TX_SEQUENCE && tx_go);
  COV_REPLY: cover property (@(posedge core_clk) !st_reg.is_live && tx_last && tx_go);
  COV_CANCEL: cover property (@(posedge core_clk) st_reg.cancel_pulse);
endmodule : bff_framer

// ---- src/bff_pkg.sv ----
// Operation
// - send liveness notices periodically while request pending
// - working status while actively processing
// - presence-needed status while awaiting user presence
// - on completion stop notices, send reply (here reply_start is taken only in TX_IDLE with a request pending)
// - all responses go out as status notifications
// - one init fragment then continuation fragments
// - init fragment: command, length high, length low
// - init fragment marked by first byte msb
// - length bytes give total payload, msb first
// - continuation starts with sequence, msb clear
// - sequence starts zero, increments, wraps after 0x7f
// - notification registration kept per bond
// - scan response service data, identifier plus flags
// - drop trailing zero flags, keep first
// - flag bit 7 pairing, bit 6 passkey
// - liveness interval is 500 ms
// - fragment limit at most mtu minus three
// - cancel aborts pending, no reply to cancel (here cancel only pulses cancel_pulse; pending is kept)
package bff_pkg;
  localparam int unsigned CLK_HZ            = 200_000_000;
  localparam int unsigned LIVENESS_MS       = 500;
  localparam int unsigned LIVENESS_CYCLES   = CLK_HZ / 1000 * LIVENESS_MS;
  localparam int unsigned INIT_HDR_BYTES    = 3;
  localparam int unsigned CONT_HDR_BYTES    = 1;
  localparam int unsigned MTU_OVERHEAD      = 3;
  localparam logic [7:0]  INIT_MARK         = 8'h80;
  localparam logic [6:0]  SEQUENCE_MAX      = 7'h7f;
  localparam int unsigned FLAG_PAIRING_BIT  = 7;
  localparam int unsigned FLAG_PASSKEY_BIT  = 6;
  localparam logic [15:0] SERVICE_ID_RESET  = 16'h0000;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } bff_beat_t;

  typedef struct packed {
    logic [7:0]  cmd;
    logic [15:0] len;
  } bff_hdr_t;
endpackage : bff_pkg

// ---- src/bff_fifo.sv ----
`timescale 1ns/10ps
module bff_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } bff_fifo_state_t;

  logic [WIDTH-1:0] mem [DEPTH];
  bff_fifo_state_t  st_reg;
  bff_fifo_state_t  st_next;
  logic             push;
  logic             pop;

  assign in_ready  = (st_reg.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.cnt != '0);
  assign out_data  = mem[st_reg.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wp = (st_reg.wp == AW'(DEPTH-1)) ? '0 : st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = (st_reg.rp == AW'(DEPTH-1)) ? '0 : st_reg.rp + 1'b1;
    end
    st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
    if (push) begin
      mem[st_reg.wp] <= in_data;
    end
  end
endmodule : bff_fifo

// ---- dv/bff_client_model.sv ----
`timescale 1ns/10ps
module bff_client_model (
  input  wire logic       core_clk,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            rx_last,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       tx_last,
  output logic            tx_ready,
  input  wire logic       slow
);
  logic [8:0] got_q[$];
  logic [1:0] phase;

  initial begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    rx_last  = 1'b0;
    tx_ready = 1'b0;
    phase    = 2'h0;
  end

  // one attribute write carries exactly one fragment
  task automatic send_frag(input logic [7:0] b[$]);
    for (int i = 0; i < b.size(); i++) begin
      @(posedge core_clk);
      #1;
      rx_data  = b[i];
      rx_valid = 1'b1;
      rx_last  = (i == b.size() - 1);
    end
    @(posedge core_clk);
    #1;
    // released line must not keep showing the last byte
    rx_data  = ~rx_data;
    rx_valid = 1'b0;
    rx_last  = 1'b0;
  endtask : send_frag

  // a notice means still busy: nothing is ever resent, no device switch
  always @(posedge core_clk) begin
    if (tx_valid && tx_ready) begin
      got_q.push_back({tx_last, tx_data});
    end
    phase    <= phase + 2'h1;
    // slow client accepts one cycle in four
    tx_ready <= #1 !slow || (phase == 2'h3);
  end
endmodule : bff_client_model

// ---- dv/ble_frame_fragmenter_liveness_notice_test.sv ----
`timescale 1ns/10ps
module ble_frame_fragmenter_liveness_notice_test;
  localparam int unsigned LIVE_N = 50;
  logic        core_clk, reset_n, slow, cancel_pulse, busy_working, busy_presence;
  logic [7:0]  rx_data, req_data, req_cmd, reply_cmd, reply_data, tx_data, svc_flags;
  logic        rx_valid, rx_last, req_valid, req_start, reply_start, reply_valid, reply_ready;
  logic        tx_valid, tx_last, tx_ready, bond_notify_enabled, notify_enabled;
  logic        pairing_mode, passkey_required, full_seen;
  logic [15:0] req_len, reply_len;
  logic [9:0]  att_mtu;
  logic [1:0]  svc_flag_len;
  logic [7:0]  req_q[$];
  logic [8:0]  exp_q[$];
  int          error_cnt, num_checks, cancel_cnt, waited;

  bff_framer #(.LIVENESS_COUNT(LIVE_N)) DUT (
    .core_clk(core_clk), .reset_n(reset_n), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_last(rx_last), .req_data(req_data), .req_valid(req_valid), .req_start(req_start),
    .req_cmd(req_cmd), .req_len(req_len), .cancel_pulse(cancel_pulse),
    .busy_working(busy_working), .busy_presence(busy_presence),
    .reply_start(reply_start), .reply_cmd(reply_cmd), .reply_len(reply_len),
    .reply_data(reply_data), .reply_valid(reply_valid), .reply_ready(reply_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
    .att_mtu(att_mtu), .bond_notify_enabled(bond_notify_enabled),
    .notify_enabled(notify_enabled), .pairing_mode(pairing_mode),
    .passkey_required(passkey_required), .svc_flags(svc_flags),
    .svc_flag_len(svc_flag_len));

  bff_client_model client (
    .core_clk(core_clk), .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
    .slow(slow));

  always #2.5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (req_valid === 1'b1) req_q.push_back(req_data);
    if (cancel_pulse === 1'b1) cancel_cnt++;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step

  task automatic wait_q(input int n);
    waited = 0;
    while (client.got_q.size() < n) begin
      step(1);
      waited++;
      if (waited > 4000) begin
        error_cnt++;
        test_done();
      end
    end
  endtask : wait_q

  // compare the notified byte stream, end marker included
  task automatic expect_tx;
    wait_q(exp_q.size());
    foreach (exp_q[i]) chk({7'h0, client.got_q.pop_front()}, {7'h0, exp_q[i]});
    exp_q.delete();
  endtask : expect_tx

  task automatic notice(input logic [7:0] st);
    exp_q = '{{1'b0, 8'h82}, 9'h000, 9'h001, {1'b1, st}};
  endtask : notice

  initial begin
    core_clk = 1'b0; reset_n = 1'b0; slow = 1'b0; busy_working = 1'b0;
    busy_presence = 1'b0; reply_start = 1'b0; reply_cmd = 8'h83; reply_len = 16'h0014;
    reply_data = 8'h00; reply_valid = 1'b0; att_mtu = 10'd23; bond_notify_enabled = 1'b1;
    pairing_mode = 1'b0; passkey_required = 1'b0; full_seen = 1'b0;
    error_cnt = 0; num_checks = 0; cancel_cnt = 0;
    step(12);
    reset_n = 1'b1;
    chk({15'h0, tx_valid}, 16'h0000);
    chk({15'h0, req_valid}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      pairing_mode = i[1];
      passkey_required = i[0];
      step(3);
      chk({8'h0, svc_flags}, {8'h0, i[1], i[0], 6'h0});
      chk({14'h0, svc_flag_len}, 16'h0001);
    end
    $display("test flags done");
    client.send_frag('{8'h81, 8'h00, 8'h02, 8'ha5, 8'h5a});
    busy_working = 1'b1;
    step(6);
    chk({8'h0, req_cmd}, 16'h0081);
    chk(req_len, 16'h0002);
    chk({8'h0, req_q[0]}, 16'h00a5);
    chk({8'h0, req_q[1]}, 16'h005a);
    $display("test request done");
    notice(8'h01);
    expect_tx();
    notice(8'h01);
    expect_tx();
    chk(16'(waited >= LIVE_N - 4 && waited <= LIVE_N + 2), 16'h0001);
    busy_presence = 1'b1;
    slow = 1'b1;
    notice(8'h02);
    expect_tx();
    $display("test liveness done");
    // registration lives in the bond store, not in the client
    bond_notify_enabled = 1'b0;
    step(4);
    client.got_q.delete();
    chk({15'h0, notify_enabled}, 16'h0000);
    step(3 * LIVE_N);
    chk(16'(client.got_q.size()), 16'h0000);
    bond_notify_enabled = 1'b1;
    step(4);
    chk({15'h0, notify_enabled}, 16'h0001);
    $display("test registration done");
    notice(8'h02);
    expect_tx();
    busy_working = 1'b0;
    busy_presence = 1'b0;
    reply_start = 1'b1;
    step(1);
    reply_start = 1'b0;
    for (int i = 0; i < 20; i++) begin
      reply_data = 8'(i + 16'h40);
      reply_valid = 1'b1;
      waited = 0;
      while (waited < 400) begin
        @(posedge core_clk);
        if (reply_ready === 1'b1) break;
        full_seen = 1'b1;
        waited++;
      end
      #1;
      if (waited >= 400) begin
        error_cnt++;
        test_done();
      end
    end
    reply_valid = 1'b0;
    chk({15'h0, full_seen}, 16'h0001);
    exp_q = '{9'h083, 9'h000, 9'h014};
    for (int i = 0; i < 17; i++) exp_q.push_back({i == 16, 8'(i + 16'h40)});
    exp_q.push_back(9'h000);
    for (int i = 17; i < 20; i++) exp_q.push_back({i == 19, 8'(i + 16'h40)});
    expect_tx();
    step(3 * LIVE_N);
    chk(16'(client.got_q.size()), 16'h0000);
    $display("test reply done");
    slow = 1'b0;
    client.send_frag('{8'h81, 8'h00, 8'h01, 8'h33});
    busy_working = 1'b1;
    client.send_frag('{8'hbe, 8'h00, 8'h00});
    step(8);
    chk(16'(cancel_cnt), 16'h0001);
    client.got_q.delete();
    notice(8'h01);
    expect_tx();
    $display("test cancel done");
    test_done();
  end
endmodule : ble_frame_fragmenter_liveness_notice_test
